// ---- logic/sew_pkg.sv ----
// constants shared by the two-wire serial memory slave
package sew_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 4096;
  localparam int PAGE_SEL_W = ADDR_W - PAGE_W;
  localparam int PIN_CNT = 6;
  localparam logic [3:0] CMD_PREFIX = 4'ha;
  localparam int CMD_RW_BIT = 0;
  localparam int CS_LSB = 1;
  localparam int CS_MSB = 3;
  localparam int PFX_LSB = 4;
  localparam int PFX_MSB = 7;
  localparam int AHI_MSB = 3;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] ACK_END = 4'h9;
  localparam logic [7:0] ERASED = 8'hff;
  localparam int PROG_TIME_US = 8000;
  localparam int CLK_MHZ = 20;
  // longest time: exact product of whole numbers, no rounding
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 18;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADHI = 3'b010,
    ST_ADLO = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101
  } sew_state_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ERASE = 2'b01,
    PH_WRITE = 2'b10,
    PH_WAIT = 2'b11
  } sew_phase_t;
endpackage

// ---- logic/sew_mem_if.sv ----
// link between protocol engine and memory core
`timescale 1ns/1ps
interface sew_mem_if;
  logic bufWr;
  logic [sew_pkg::PAGE_W-1:0] bufIdx;
  logic [sew_pkg::DATA_W-1:0] bufData;
  logic bufClr;
  logic progGo;
  logic [sew_pkg::PAGE_SEL_W-1:0] pageSel;
  logic busy;
  logic [sew_pkg::ADDR_W-1:0] rdAddr;
  logic [sew_pkg::DATA_W-1:0] rdData;
  modport ctrl(output bufWr, bufIdx, bufData, bufClr, progGo, pageSel,
    rdAddr, input busy, rdData);
  modport mem(input bufWr, bufIdx, bufData, bufClr, progGo, pageSel,
    rdAddr, output busy, rdData);
endinterface

// ---- logic/sew_memory.sv ----
// memory array, page buffer and self-timed programming cycle
`timescale 1ns/1ps
module sew_memory #(
  parameter int PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  sew_mem_if.mem port
);
  logic [sew_pkg::DATA_W-1:0] memArr [0:sew_pkg::MEM_BYTES-1];
  logic [sew_pkg::DATA_W-1:0] pageBuf [0:sew_pkg::PAGE_BYTES-1];
  logic [sew_pkg::PAGE_BYTES-1:0] mask_r;
  sew_pkg::sew_phase_t phase_r;
  logic [sew_pkg::PAGE_W-1:0] idx_r;
  logic [sew_pkg::TIMER_W-1:0] timer_r;
  logic [sew_pkg::PAGE_SEL_W-1:0] page_r;
  logic [sew_pkg::DATA_W-1:0] rdData_r;
  logic [sew_pkg::TIMER_W-1:0] lastTick;

  assign lastTick = sew_pkg::TIMER_W'(PROG_CYCLES - 1);
  assign port.busy = (phase_r != sew_pkg::PH_IDLE);
  assign port.rdData = rdData_r;

  // untouched page bytes keep their mask bit clear
  genvar g;
  generate
    for (g = 0; g < sew_pkg::PAGE_BYTES; g++) begin : g_entry
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          mask_r[g] <= 1'b0;
        end else if (ce) begin
          if (port.bufClr) begin
            mask_r[g] <= 1'b0;
          end else if (port.bufWr && port.bufIdx == g) begin
            mask_r[g] <= 1'b1;
          end
        end
      end
      always_ff @(posedge sys_clk) begin
        if (ce && port.bufWr && port.bufIdx == g) begin
          pageBuf[g] <= port.bufData;
        end
      end
    end
  endgenerate

  // erase pass, then write pass, then hold busy to the full cycle time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_r <= sew_pkg::PH_IDLE;
      idx_r <= '0;
      timer_r <= '0;
      page_r <= '0;
    end else if (ce) begin
      case (phase_r)
        sew_pkg::PH_IDLE: begin
          timer_r <= '0;
          idx_r <= '0;
          if (port.progGo) begin
            page_r <= port.pageSel;
            phase_r <= sew_pkg::PH_ERASE;
          end
        end
        sew_pkg::PH_ERASE: begin
          timer_r <= timer_r + 1'b1;
          idx_r <= idx_r + 1'b1;
          if (&idx_r) begin
            phase_r <= sew_pkg::PH_WRITE;
          end
        end
        sew_pkg::PH_WRITE: begin
          timer_r <= timer_r + 1'b1;
          idx_r <= idx_r + 1'b1;
          if (&idx_r) begin
            phase_r <= sew_pkg::PH_WAIT;
          end
        end
        sew_pkg::PH_WAIT: begin
          timer_r <= timer_r + 1'b1;
          if (timer_r >= lastTick) begin
            phase_r <= sew_pkg::PH_IDLE;
          end
        end
        default: phase_r <= sew_pkg::PH_IDLE;
      endcase
    end
  end

  // array has no reset; contents survive like real cells
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      rdData_r <= memArr[port.rdAddr];
      if (phase_r == sew_pkg::PH_ERASE && mask_r[idx_r]) begin
        memArr[{page_r, idx_r}] <= sew_pkg::ERASED;
      end else if (phase_r == sew_pkg::PH_WRITE && mask_r[idx_r]) begin
        memArr[{page_r, idx_r}] <= pageBuf[idx_r];
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_erase_first: assert property (
    ce && phase_r == sew_pkg::PH_IDLE && port.progGo |=>
      phase_r == sew_pkg::PH_ERASE && idx_r == '0)
    else $error("programming did not begin with erase");
endmodule

// ---- logic/sew_slave.sv ----
// two-wire serial memory slave: protocol engine and pin handling
//
// Overview of operation
// - start and stop seen while clock high
// - stop after write data starts programming
// - receiver pulls data low in ninth clock
// - data changes on clock low, MSB first
// - command bits 3..1 match chip straps
// - command bit 0: zero write, one read
// - command prefix is one zero one zero
// - address advances after write and read bytes
// - keep sending while master keeps acknowledging
// - write protect high suppresses all programming
// - byte write acks command, addresses, data
// - programming erases to ones, then writes
// - programming ends within its maximum time
// - up to 32 bytes collected before stop
// - page writes wrap within low five bits
// - unaddressed page bytes stay unchanged
// - no command ack while programming runs
// - address stays on last entered byte
// - random read: address write, restart, read
// - write protect low allows normal operation
`timescale 1ns/1ps
module sew_slave #(
  parameter int PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic writeProtect,
  input wire logic chip_select_strap_0,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_2,
  output logic progBusy
);
  sew_mem_if memLink();

  logic [sew_pkg::PIN_CNT-1:0] pinRaw;
  logic [sew_pkg::PIN_CNT-1:0] pinMeta_r;
  logic [sew_pkg::PIN_CNT-1:0] pinSync_r;
  logic sclPrev_r;
  logic sdaPrev_r;
  logic sclS;
  logic sdaS;
  logic wpS;
  logic [2:0] csS;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic byteDone;
  logic ackEnd;
  logic cmdMatch;
  logic ackNow;

  sew_pkg::sew_state_t state_r;
  logic [3:0] cnt_r;
  logic [sew_pkg::DATA_W-1:0] shIn_r;
  logic [sew_pkg::DATA_W-1:0] txByte_r;
  logic mAck_r;
  logic [sew_pkg::ADDR_W-1:0] addr_r;
  logic incPend_r;
  logic dataSeen_r;
  logic progGo_r;
  logic sdaOeN_r;
  logic sdaOut_r;
  logic progBusy_r;

  sew_memory #(.PROG_CYCLES(PROG_CYCLES)) u_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .port(memLink.mem)
  );

  assign pinRaw = {chip_select_strap_2, chip_select_strap_1,
    chip_select_strap_0, writeProtect, sdaIn, sclIn};

  // pins come from outside the clock domain
  genvar g;
  generate
    for (g = 0; g < sew_pkg::PIN_CNT; g++) begin : g_sync
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pinMeta_r[g] <= 1'b1;
          pinSync_r[g] <= 1'b1;
        end else if (ce) begin
          pinMeta_r[g] <= pinRaw[g];
          pinSync_r[g] <= pinMeta_r[g];
        end
      end
    end
  endgenerate

  assign sclS = pinSync_r[0];
  assign sdaS = pinSync_r[1];
  assign wpS = pinSync_r[2];
  assign csS = pinSync_r[5:3];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else if (ce) begin
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
    end
  end

  // edges are only taken while ce is high
  always_comb begin
    sclRise = ce && sclS && !sclPrev_r;
    sclFall = ce && !sclS && sclPrev_r;
    startEv = ce && sclS && sclPrev_r && sdaPrev_r && !sdaS;
    stopEv = ce && sclS && sclPrev_r && !sdaPrev_r && sdaS;
    byteDone = sclFall && cnt_r == sew_pkg::ACK_SLOT;
    ackEnd = sclFall && cnt_r == sew_pkg::ACK_END;
    cmdMatch = shIn_r[sew_pkg::PFX_MSB:sew_pkg::PFX_LSB]
        == sew_pkg::CMD_PREFIX
      && shIn_r[sew_pkg::CS_MSB:sew_pkg::CS_LSB] == csS
      && !memLink.busy;
    case (state_r)
      sew_pkg::ST_CMD: ackNow = byteDone && cmdMatch;
      sew_pkg::ST_ADHI,
      sew_pkg::ST_ADLO,
      sew_pkg::ST_WDATA: ackNow = byteDone;
      default: ackNow = 1'b0;
    endcase
  end

  // bit counter: eight data bits, then the ack slot
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      shIn_r <= 8'h00;
      mAck_r <= 1'b0;
    end else if (ce) begin
      if (startEv || stopEv) begin
        cnt_r <= 4'h0;
      end else if (sclRise) begin
        if (cnt_r <= sew_pkg::BIT_LAST) begin
          shIn_r <= {shIn_r[6:0], sdaS};
          cnt_r <= cnt_r + 4'h1;
        end else if (cnt_r == sew_pkg::ACK_SLOT) begin
          mAck_r <= !sdaS;
          cnt_r <= sew_pkg::ACK_END;
        end
      end else if (ackEnd) begin
        cnt_r <= 4'h0;
      end
    end
  end

  // protocol state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= sew_pkg::ST_IDLE;
    end else if (ce) begin
      if (startEv) begin
        state_r <= sew_pkg::ST_CMD;
      end else if (stopEv) begin
        state_r <= sew_pkg::ST_IDLE;
      end else if (byteDone) begin
        case (state_r)
          sew_pkg::ST_CMD: begin
            if (!cmdMatch) begin
              state_r <= sew_pkg::ST_IDLE;
            end else if (shIn_r[sew_pkg::CMD_RW_BIT]) begin
              state_r <= sew_pkg::ST_RDATA;
            end else begin
              state_r <= sew_pkg::ST_ADHI;
            end
          end
          sew_pkg::ST_ADHI: state_r <= sew_pkg::ST_ADLO;
          sew_pkg::ST_ADLO: state_r <= sew_pkg::ST_WDATA;
          sew_pkg::ST_WDATA: state_r <= sew_pkg::ST_WDATA;
          sew_pkg::ST_RDATA: state_r <= sew_pkg::ST_RDATA;
          default: state_r <= sew_pkg::ST_IDLE;
        endcase
      end else if (ackEnd && state_r == sew_pkg::ST_RDATA && !mAck_r) begin
        state_r <= sew_pkg::ST_IDLE;
      end
    end
  end

  // address counter; a write step waits for the first fall inside the
  // next byte: a stop rides on a clock rise, so the counter still names
  // the last entered byte when programming starts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_r <= 12'h000;
      incPend_r <= 1'b0;
    end else if (ce) begin
      if (startEv) begin
        incPend_r <= 1'b0;
      end else if (byteDone) begin
        case (state_r)
          sew_pkg::ST_ADHI: begin
            addr_r[sew_pkg::ADDR_W-1:sew_pkg::DATA_W] <=
              shIn_r[sew_pkg::AHI_MSB:0];
          end
          sew_pkg::ST_ADLO: begin
            addr_r[sew_pkg::DATA_W-1:0] <= shIn_r;
            incPend_r <= 1'b0;
          end
          sew_pkg::ST_WDATA: incPend_r <= 1'b1;
          sew_pkg::ST_RDATA: addr_r <= addr_r + 12'h001;
          default: incPend_r <= incPend_r;
        endcase
      end else if (sclFall && cnt_r == 4'h1 && incPend_r
          && state_r == sew_pkg::ST_WDATA) begin
        addr_r[sew_pkg::PAGE_W-1:0] <=
          addr_r[sew_pkg::PAGE_W-1:0] + 5'h01;
        incPend_r <= 1'b0;
      end
    end
  end

  // write session bookkeeping and the programming kick
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataSeen_r <= 1'b0;
      progGo_r <= 1'b0;
    end else if (ce) begin
      progGo_r <= 1'b0;
      if (startEv) begin
        dataSeen_r <= 1'b0; // a restart abandons the write
      end else if (stopEv) begin
        dataSeen_r <= 1'b0;
        progGo_r <= dataSeen_r && state_r == sew_pkg::ST_WDATA
          && !wpS;
      end else if (byteDone && state_r == sew_pkg::ST_WDATA) begin
        dataSeen_r <= 1'b1;
      end
    end
  end

  // open drain: enable low pulls the line to sdaOut, which stays zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sdaOeN_r <= 1'b1;
      sdaOut_r <= 1'b0;
      txByte_r <= 8'h00;
    end else if (ce) begin
      sdaOut_r <= 1'b0;
      if (startEv || stopEv) begin
        sdaOeN_r <= 1'b1;
      end else if (byteDone) begin
        sdaOeN_r <= !ackNow;
      end else if (ackEnd) begin
        if (state_r == sew_pkg::ST_RDATA && mAck_r) begin
          txByte_r <= memLink.rdData;
          sdaOeN_r <= memLink.rdData[7];
        end else begin
          sdaOeN_r <= 1'b1;
        end
      end else if (sclFall && state_r == sew_pkg::ST_RDATA) begin
        sdaOeN_r <= txByte_r[3'(sew_pkg::BIT_LAST - cnt_r)];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      progBusy_r <= 1'b0;
    end else if (ce) begin
      progBusy_r <= memLink.busy;
    end
  end

  assign memLink.bufWr = byteDone && state_r == sew_pkg::ST_WDATA;
  assign memLink.bufIdx = addr_r[sew_pkg::PAGE_W-1:0];
  assign memLink.bufData = shIn_r;
  assign memLink.bufClr = byteDone && state_r == sew_pkg::ST_ADLO;
  assign memLink.progGo = progGo_r;
  assign memLink.pageSel = addr_r[sew_pkg::ADDR_W-1:sew_pkg::PAGE_W];
  assign memLink.rdAddr = addr_r;

  assign sdaOut = sdaOut_r;
  assign sdaOeN = sdaOeN_r;
  assign progBusy = progBusy_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_kick;
    progGo_r ##2 progBusy_r;
  endsequence

  a_start_to_cmd: assert property (
    startEv |=> state_r == sew_pkg::ST_CMD && cnt_r == 4'h0 && sdaOeN_r)
    else $error("start did not open a command byte");

  a_stop_programs: assert property (
    stopEv && dataSeen_r && state_r == sew_pkg::ST_WDATA && !wpS
      |=> s_kick)
    else $error("stop after write data did not start programming");

  a_ack_match: assert property (
    byteDone && state_r == sew_pkg::ST_CMD && cmdMatch
      |=> !sdaOeN_r throughout (!sclFall [*1]))
    else $error("matching command byte not acknowledged");

  a_busy_no_ack: assert property (
    byteDone && state_r == sew_pkg::ST_CMD && memLink.busy
      |=> sdaOeN_r && state_r == sew_pkg::ST_IDLE)
    else $error("command acknowledged while programming");

  a_wp_blocks: assert property (
    stopEv && wpS |=> !progGo_r ##1 !progGo_r)
    else $error("programming started under write protect");

  a_page_wrap: assert property (
    sclFall && cnt_r == 4'h1 && incPend_r && state_r == sew_pkg::ST_WDATA
      |=> addr_r[11:5] == $past(addr_r[11:5])
        && addr_r[4:0] == $past(addr_r[4:0]) + 5'h01)
    else $error("page address left its page");

  a_read_inc: assert property (
    byteDone && state_r == sew_pkg::ST_RDATA
      |=> addr_r == $past(addr_r) + 12'h001 && sdaOeN_r)
    else $error("read did not advance address or release line");

  a_nomatch_quiet: assert property (
    state_r == sew_pkg::ST_IDLE && !startEv |=> sdaOeN_r)
    else $error("line driven while not selected");

  a_ack_release: assert property (
    ackEnd && !(state_r == sew_pkg::ST_RDATA && mAck_r) |=> sdaOeN_r)
    else $error("data line held after acknowledge slot");

  a_busy_addr_hold: assert property (
    memLink.busy |=> addr_r == $past(addr_r))
    else $error("address moved during programming");
endmodule

// ---- verif/sew_bus_master.sv ----
// behavioural two-wire bus master that drives clock and data
`timescale 1ns/1ps
module sew_bus_master #(
  parameter int QUARTER = 2
) (
  input wire logic sys_clk,
  input wire logic sdaWire,
  output logic sclDrv,
  output logic sdaDrv
);
  // clock stands high and data is released outside frames
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end

  // every change lands on the falling edge of the system clock
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // works from idle and as a repeated start from a low clock
  task automatic busStart();
    sdaDrv = 1'b1;
    // a full low phase lets the slave drop its ack before the clock rises
    tick(2 * QUARTER);
    sclDrv = 1'b1;
    tick(2 * QUARTER);
    sdaDrv = 1'b0;
    tick(2 * QUARTER);
    sclDrv = 1'b0;
  endtask

  task automatic busStop();
    tick(QUARTER);
    sdaDrv = 1'b0;
    tick(QUARTER);
    sclDrv = 1'b1;
    tick(2 * QUARTER);
    sdaDrv = 1'b1;
    tick(2 * QUARTER);
  endtask

  // data moves mid low phase; sampled late in high phase
  task automatic pulse(input logic bitOut, output logic bitIn);
    tick(QUARTER);
    sdaDrv = bitOut;
    tick(QUARTER);
    sclDrv = 1'b1;
    tick(2 * QUARTER - 1);
    bitIn = sdaWire;
    tick(1);
    sclDrv = 1'b0;
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], s);
    end
    pulse(1'b1, s);
    ack = (s === 1'b0);
  endtask

  task automatic recvByte(output logic [7:0] d, input logic ackIt);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, d[i]);
    end
    pulse(!ackIt, s);
  endtask
endmodule

// ---- verif/tb_top.sv ----
// self-checking testbench for the two-wire memory slave
`timescale 1ns/1ps
module tb_top;
  localparam int PROG = 400;
  localparam logic [2:0] STRAPS = 3'h5;
  logic sys_clk;
  logic rst;
  logic writeProtect;
  logic [2:0] straps;
  logic sdaOut;
  logic sdaOeN;
  logic progBusy;
  logic sclDrv;
  logic sdaDrv;
  logic sdaWire;
  logic [7:0] expMem [0:4095];
  int n_mismatch = 0;
  int samples_checked = 0;

  // open-drain wire with pull-up
  assign sdaWire = sdaDrv & (sdaOeN | sdaOut);

  sew_slave #(.PROG_CYCLES(PROG)) i_sew_slave (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(1'b1),
    .sclIn(sclDrv),
    .sdaIn(sdaWire),
    .sdaOut(sdaOut),
    .sdaOeN(sdaOeN),
    .writeProtect(writeProtect),
    .chip_select_strap_0(straps[0]),
    .chip_select_strap_1(straps[1]),
    .chip_select_strap_2(straps[2]),
    .progBusy(progBusy)
  );

  sew_bus_master i_sew_bus_master (
    .sys_clk(sys_clk),
    .sdaWire(sdaWire),
    .sclDrv(sclDrv),
    .sdaDrv(sdaDrv)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chkBit(input string what, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chkByte(input string what, input logic [7:0] e,
      input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic sendCmd(input logic [7:0] b, input logic expAck);
    logic a;
    i_sew_bus_master.busStart();
    i_sew_bus_master.sendByte(b, a);
    chkBit("command ack", expAck, a);
  endtask

  task automatic putByte(input logic [7:0] b);
    logic a;
    i_sew_bus_master.sendByte(b, a);
    chkBit("byte ack", 1'b1, a);
  endtask

  task automatic setAddr(input logic [11:0] a);
    sendCmd({sew_pkg::CMD_PREFIX, STRAPS, 1'b0}, 1'b1);
    putByte({4'h0, a[11:8]});
    putByte(a[7:0]);
  endtask

  // page writes wrap in the low five bits
  task automatic writeSeq(input logic [11:0] a, input logic [7:0] d0,
      input int n);
    logic [11:0] p;
    p = a;
    setAddr(a);
    for (int i = 0; i < n; i++) begin
      putByte(d0 + 8'(i));
      if (!writeProtect) expMem[p] = d0 + 8'(i);
      p[4:0] = p[4:0] + 5'h1;
    end
    i_sew_bus_master.busStop();
  endtask

  task automatic waitProg(input logic expBusy);
    int k;
    k = 0;
    while (progBusy !== 1'b1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    chkBit("programming started", expBusy, progBusy);
    if (expBusy) begin
      sendCmd({sew_pkg::CMD_PREFIX, STRAPS, 1'b1}, 1'b0);
      i_sew_bus_master.busStop();
      k = 0;
      while (progBusy !== 1'b0 && k < PROG + 40) begin
        @(negedge sys_clk);
        k++;
      end
      chkBit("programming ended", 1'b0, progBusy);
    end
    sendCmd({sew_pkg::CMD_PREFIX, STRAPS, 1'b0}, 1'b1);
    i_sew_bus_master.busStop();
  endtask

  // master acks all but the last byte
  task automatic readSeq(input logic [11:0] a, input int n,
      input logic withAddr);
    logic [7:0] d;
    logic [11:0] p;
    p = a;
    if (withAddr) setAddr(a);
    sendCmd({sew_pkg::CMD_PREFIX, STRAPS, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_sew_bus_master.recvByte(d, i < n - 1);
      chkByte("read data", expMem[p], d);
      p = p + 12'h1;
    end
    i_sew_bus_master.busStop();
    chkBit("data line released", 1'b1, sdaOeN);
  endtask

  initial begin
    logic [7:0] c;
    logic hit;
    logic a;
    rst = 1'b1;
    writeProtect = 1'b0;
    straps = STRAPS;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chkBit("released after reset", 1'b1, sdaOeN);
    chkBit("open drain value", 1'b0, sdaOut);
    chkBit("idle after reset", 1'b0, progBusy);
    writeSeq(12'h022, 8'h77, 1);
    waitProg(1'b1);
    readSeq(12'h022, 1, 1'b0);
    writeSeq(12'h03e, 8'ha0, 4);
    waitProg(1'b1);
    readSeq(12'h03e, 2, 1'b1);
    readSeq(12'h020, 3, 1'b1);
    // restart abandoned the address write: nothing programs
    chkBit("busy after read", 1'b0, progBusy);
    writeProtect = 1'b1;
    writeSeq(12'h03e, 8'h11, 1);
    waitProg(1'b0);
    writeProtect = 1'b0;
    readSeq(12'h03e, 1, 1'b1);
    for (int i = 0; i < 12; i++) begin
      c = (i < 8) ? {sew_pkg::CMD_PREFIX, 3'(i), 1'b0}
          : {sew_pkg::CMD_PREFIX ^ (4'h1 << (i - 8)), STRAPS, 1'b0};
      hit = (i < 8) && (3'(i) == STRAPS);
      sendCmd(c, hit);
      if (!hit) begin
        i_sew_bus_master.sendByte(8'h00, a);
        chkBit("ignored byte ack", 1'b0, a);
      end
      i_sew_bus_master.busStop();
    end
    complete_run();
  end

  // the whole run needs well under this span
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
